// >>> pkg/mso_defs.svh
// address map, reset values and scaling constants of the start-up option bank
`ifndef MSO_DEFS_SVH
`define MSO_DEFS_SVH
`define MSO_ADDR_STARTUP 8'h25
`define MSO_ADDR_THR_ALIGN 8'h26
`define MSO_ADDR_FAULT 8'h27
`define MSO_ADDR_LIMIT 8'h28
`define MSO_ADDR_CLOSED 8'h29
`define MSO_RESET_VAL 8'h00
`define MSO_LIMIT_WMASK 8'hFE
`define MSO_COEF_OFFSET 3'h1
`define MSO_THR0_STEP_DHZ 12'h008
`define MSO_THR1_STEP_DHZ 12'h080
`define MSO_ACL_STEP_MA 12'h0C8
`define MSO_LCL_STEP_MA 12'h190
`define MSO_DT_STEP_NS 10'h028
`define MSO_CLK_NS 10'h00A
`define MSO_DT_STEP_CYC 8'((`MSO_DT_STEP_NS + `MSO_CLK_NS - 10'h001) / `MSO_CLK_NS)
`endif

// >>> pkg/mso_pkg.sv
// field layouts of the five option registers
package mso_pkg;
    typedef struct packed {logic [1:0] coef; logic [2:0] accel2; logic [2:0] accel1;} mso_startup_t;
    typedef struct packed {logic range_hi; logic [3:0] thr_n; logic [2:0] align;} mso_thr_align_t;
    typedef struct packed {
        logic no_motor;
        logic [2:0] lock_det;
        logic ind_surge;
        logic mech_surge;
        logic clamp_24v;
        logic release_hiz;
    } mso_fault_t;
    typedef struct packed {logic [3:0] accel_lim; logic [2:0] lock_lim; logic spare;} mso_limit_t;
    typedef struct packed {logic stall_en; logic [2:0] cl_accel; logic [3:0] dead;} mso_closed_t;
endpackage

// >>> pkg/mso_cfg_if.sv
// raw option register contents passed from the register file to the decoder
`timescale 1ns/1ps
interface mso_cfg_if;
    import mso_pkg::*;
    mso_startup_t startup;
    mso_thr_align_t thr_align;
    mso_fault_t fault;
    mso_limit_t limit;
    mso_closed_t closed;
    logic update;
    modport src (output startup, thr_align, fault, limit, closed, update);
    modport snk (input startup, thr_align, fault, limit, closed, update);
endinterface

// >>> logic/mso_reg_file.sv
// option register storage with write decode and registered read port
`timescale 1ns/1ps
`include "mso_defs.svh"
module mso_reg_file (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic rvalid,
    mso_cfg_if.src cfg
);
    import mso_pkg::*;
    logic [7:0] regs_q [5];
    logic [7:0] regs_d [5];
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, upd_q, upd_d;
    logic [2:0] idx;
    logic hit;

    // address decode shared by read and write
    always_comb begin
        hit = 1'b1;
        idx = 3'h0;
        unique case (addr)
            `MSO_ADDR_STARTUP: idx = 3'h0;
            `MSO_ADDR_THR_ALIGN: idx = 3'h1;
            `MSO_ADDR_FAULT: idx = 3'h2;
            `MSO_ADDR_LIMIT: idx = 3'h3;
            `MSO_ADDR_CLOSED: idx = 3'h4;
            default: hit = 1'b0;
        endcase
    end

    // writes land in one cycle; the spare bit is never stored so it reads zero
    always_comb begin
        regs_d = regs_q;
        upd_d = wr && hit;
        if (wr && hit) begin
            regs_d[idx] = (addr == `MSO_ADDR_LIMIT) ? (wdata & `MSO_LIMIT_WMASK) : wdata;
        end
        rdata_d = (rd && hit) ? regs_q[idx] : `MSO_RESET_VAL;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 5; i++) begin
                regs_q[i] <= `MSO_RESET_VAL;
            end
            rdata_q <= `MSO_RESET_VAL;
            rvalid_q <= 1'b0;
            upd_q <= 1'b0;
        end else begin
            regs_q <= regs_d;
            rdata_q <= rdata_d;
            rvalid_q <= rd;
            upd_q <= upd_d;
        end
    end

    assign rdata = rdata_q;
    assign rvalid = rvalid_q;
    assign cfg.startup = regs_q[0];
    assign cfg.thr_align = regs_q[1];
    assign cfg.fault = regs_q[2];
    assign cfg.limit = regs_q[3];
    assign cfg.closed = regs_q[4];
    assign cfg.update = upd_q;

    sequence s_wr_closed;
        wr && (addr == `MSO_ADDR_CLOSED) && !rd;
    endsequence
    sequence s_rd_closed;
        !wr && rd && (addr == `MSO_ADDR_CLOSED);
    endsequence
    property p_readback;
        logic [7:0] v;
        @(posedge clk) disable iff (!reset_n)
        (s_wr_closed, v = wdata) ##1 s_rd_closed |=> rvalid_q && (rdata_q == v);
    endproperty
    a_readback: assert property (p_readback) else $error("read did not return written value");
    property p_spare_zero;
        @(posedge clk) disable iff (!reset_n)
        rd && (addr == `MSO_ADDR_LIMIT) |=> !rdata_q[0];
    endproperty
    a_spare_zero: assert property (p_spare_zero) else $error("spare bit read as one");
endmodule

// >>> logic/mso_deadtime.sv
// one phase leg: break-before-make gate drive with programmable gap
`timescale 1ns/1ps
module mso_deadtime (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic drive_en,
    input wire logic drive_high,
    input wire logic [7:0] dead_cycles,
    output logic gate_hs,
    output logic gate_ls
);
    logic hs_q, hs_d, ls_q, ls_d;
    logic [7:0] cnt_q, cnt_d;
    logic want_hs, want_ls;

    // a gate is dropped first, then the other waits out the gap before turning on
    always_comb begin
        want_hs = drive_en && drive_high;
        want_ls = drive_en && !drive_high;
        hs_d = hs_q;
        ls_d = ls_q;
        cnt_d = cnt_q;
        if ((hs_q != want_hs) || (ls_q != want_ls)) begin
            if (hs_q || ls_q) begin
                hs_d = 1'b0;
                ls_d = 1'b0;
                cnt_d = dead_cycles - 8'h01;
            end else if (cnt_q != 8'h00) begin
                cnt_d = cnt_q - 8'h01;
            end else begin
                hs_d = want_hs;
                ls_d = want_ls;
            end
        end else if (cnt_q != 8'h00) begin
            cnt_d = cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hs_q <= 1'b0;
            ls_q <= 1'b0;
            cnt_q <= 8'h00;
        end else begin
            hs_q <= hs_d;
            ls_q <= ls_d;
            cnt_q <= cnt_d;
        end
    end

    assign gate_hs = hs_q;
    assign gate_ls = ls_q;

    property p_no_overlap;
        @(posedge clk) disable iff (!reset_n) !(hs_q && ls_q);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both gates on");
    property p_min_gap;
        @(posedge clk) disable iff (!reset_n) $fell(hs_q) |-> !ls_q [*4];
    endproperty
    a_min_gap: assert property (p_min_gap) else $error("dead time shorter than one step");
endmodule

// >>> logic/mso_startup_option_regs.sv
// start-up option bank: register file, field decode, loop transfer and gate dead time
`timescale 1ns/1ps
`include "mso_defs.svh"
// Notes on behaviour
// - coefficient code n gives (n+1) quarters
// - second-order start acceleration from eight-entry table
// - first-order start acceleration from eight-entry table
// - low range threshold is n times 0.8 Hz
// - high range threshold is (n+1) times 12.8 Hz
// - align duration from eight-entry table
// - no-motor fault enable follows its bit
// - back-emf constant lock enable follows its bit
// - abnormal speed lock enable follows its bit
// - current-limit lock enable follows its bit
// - inductive surge protection enable follows its bit
// - mechanical surge protection enable follows its bit
// - clamp target: supply or 24 V
// - release after sensing brakes or floats phases
// - acceleration limit n times 0.2 A, zero disables
// - lock limit (n+1) times 0.4 A, bit0 unused
// - closed-loop stall detection enable follows its bit
// - closed-loop acceleration from table, code zero unlimited
// - dead time (n+1) times 40 ns per phase
// - enter closed loop at threshold unless disabled
module mso_startup_option_regs #(
    parameter int SPEED_W = 12,
    parameter int PHASES = 3
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic open_loop_run,
    input wire logic [SPEED_W-1:0] motor_speed,
    input wire logic closed_loop_transfer_disable,
    input wire logic sense_release,
    input wire logic [PHASES-1:0] phase_drive_en,
    input wire logic [PHASES-1:0] phase_drive_high,
    output logic [2:0] control_coefficient,
    output logic [15:0] startup_accel_second_order,
    output logic [16:0] startup_accel_first_order,
    output logic [11:0] loop_transfer_threshold,
    output logic loop_transfer_threshold_valid,
    output logic [15:0] align_duration,
    output logic no_motor_fault_enable,
    output logic [2:0] lock_detect_enables,
    output logic inductive_surge_protect_enable,
    output logic mechanical_surge_protect_enable,
    output logic mechanical_surge_clamp_select,
    output logic sense_release_mode,
    output logic [11:0] accel_current_limit,
    output logic accel_current_limit_enable,
    output logic [11:0] lock_current_limit,
    output logic closed_loop_stall_enable,
    output logic [15:0] closed_loop_accel_rate,
    output logic closed_loop_accel_unlimited,
    output logic [9:0] dead_time_ns,
    output logic closed_loop_request,
    output logic phase_brake,
    output logic phase_hiz,
    output logic [PHASES-1:0] gate_hs,
    output logic [PHASES-1:0] gate_ls
);
    import mso_pkg::*;

    mso_cfg_if cfg ();

    mso_reg_file u_regs (
        .clk(clk),
        .reset_n(reset_n),
        .wr(reg_wr),
        .rd(reg_rd),
        .addr(reg_addr),
        .wdata(reg_wdata),
        .rdata(reg_rdata),
        .rvalid(reg_rvalid),
        .cfg(cfg.src)
    );

    // second-order acceleration in mHz/s^2
    function automatic logic [15:0] accel2_lut(input logic [2:0] c);
        unique case (c)
            3'h0: accel2_lut = 16'hDEA8;
            3'h1: accel2_lut = 16'h7148;
            3'h2: accel2_lut = 16'h36B0;
            3'h3: accel2_lut = 16'h1AF4;
            3'h4: accel2_lut = 16'h0CE4;
            3'h5: accel2_lut = 16'h0640;
            3'h6: accel2_lut = 16'h0294;
            3'h7: accel2_lut = 16'h00DC;
        endcase
    endfunction

    // first-order acceleration in mHz/s; top entry needs seventeen bits
    function automatic logic [16:0] accel1_lut(input logic [2:0] c);
        unique case (c)
            3'h0: accel1_lut = 17'h128E0;
            3'h1: accel1_lut = 17'h09470;
            3'h2: accel1_lut = 17'h04A38;
            3'h3: accel1_lut = 17'h023F0;
            3'h4: accel1_lut = 17'h01194;
            3'h5: accel1_lut = 17'h00834;
            3'h6: accel1_lut = 17'h00384;
            3'h7: accel1_lut = 17'h0012C;
        endcase
    endfunction

    // align duration in ms
    function automatic logic [15:0] align_lut(input logic [2:0] c);
        unique case (c)
            3'h0: align_lut = 16'h14B4;
            3'h1: align_lut = 16'h0A8C;
            3'h2: align_lut = 16'h0514;
            3'h3: align_lut = 16'h029E;
            3'h4: align_lut = 16'h014A;
            3'h5: align_lut = 16'h00A0;
            3'h6: align_lut = 16'h0050;
            3'h7: align_lut = 16'h0028;
        endcase
    endfunction

    // closed-loop rate in milli supply-volts per second; code zero has no finite value
    function automatic logic [15:0] cl_accel_lut(input logic [2:0] c);
        unique case (c)
            3'h0: cl_accel_lut = 16'h0000;
            3'h1: cl_accel_lut = 16'hBB80;
            3'h2: cl_accel_lut = 16'hBB80;
            3'h3: cl_accel_lut = 16'h0302;
            3'h4: cl_accel_lut = 16'h0172;
            3'h5: cl_accel_lut = 16'h00BE;
            3'h6: cl_accel_lut = 16'h005B;
            3'h7: cl_accel_lut = 16'h002D;
        endcase
    endfunction

    // one load right after reset so outputs reflect the reset contents
    logic init_q, init_d;
    logic load;
    assign init_d = 1'b0;
    assign load = cfg.update || init_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            init_q <= 1'b1;
        end else begin
            init_q <= init_d;
        end
    end

    // decoded settings, held between writes
    logic [2:0] coef_q, coef_d;
    logic [15:0] acc2_q, acc2_d;
    logic [16:0] acc1_q, acc1_d;
    logic [11:0] thr_q, thr_d;
    logic thr_ok_q, thr_ok_d;
    logic [15:0] align_q, align_d;
    logic [7:0] en_q, en_d;
    logic [11:0] acl_q, acl_d;
    logic acl_en_q, acl_en_d;
    logic [11:0] lcl_q, lcl_d;
    logic stall_q, stall_d;
    logic [15:0] cla_q, cla_d;
    logic cla_inf_q, cla_inf_d;
    logic [9:0] dtns_q, dtns_d;
    logic [7:0] dtcyc_q, dtcyc_d;

    always_comb begin
        coef_d = coef_q;
        acc2_d = acc2_q;
        acc1_d = acc1_q;
        thr_d = thr_q;
        thr_ok_d = thr_ok_q;
        align_d = align_q;
        en_d = en_q;
        acl_d = acl_q;
        acl_en_d = acl_en_q;
        lcl_d = lcl_q;
        stall_d = stall_q;
        cla_d = cla_q;
        cla_inf_d = cla_inf_q;
        dtns_d = dtns_q;
        dtcyc_d = dtcyc_q;
        if (load) begin
            coef_d = 3'(cfg.startup.coef) + `MSO_COEF_OFFSET;
            acc2_d = accel2_lut(cfg.startup.accel2);
            acc1_d = accel1_lut(cfg.startup.accel1);
            if (cfg.thr_align.range_hi) begin
                thr_d = 12'((12'(cfg.thr_align.thr_n) + 12'h001) * `MSO_THR1_STEP_DHZ);
                thr_ok_d = 1'b1;
            end else begin
                thr_d = 12'(12'(cfg.thr_align.thr_n) * `MSO_THR0_STEP_DHZ);
                thr_ok_d = (cfg.thr_align.thr_n != 4'h0);
            end
            align_d = align_lut(cfg.thr_align.align);
            // fault and surge bits pass through as a byte, kept in register order
            en_d = cfg.fault;
            acl_d = 12'(12'(cfg.limit.accel_lim) * `MSO_ACL_STEP_MA);
            acl_en_d = (cfg.limit.accel_lim != 4'h0);
            lcl_d = 12'((12'(cfg.limit.lock_lim) + 12'h001) * `MSO_LCL_STEP_MA);
            stall_d = cfg.closed.stall_en;
            cla_d = cl_accel_lut(cfg.closed.cl_accel);
            cla_inf_d = (cfg.closed.cl_accel == 3'h0);
            dtns_d = 10'((10'(cfg.closed.dead) + 10'h001) * `MSO_DT_STEP_NS);
            dtcyc_d = 8'((8'(cfg.closed.dead) + 8'h01) * `MSO_DT_STEP_CYC);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            coef_q <= 3'h0;
            acc2_q <= 16'h0000;
            acc1_q <= 17'h00000;
            thr_q <= 12'h000;
            thr_ok_q <= 1'b0;
            align_q <= 16'h0000;
            en_q <= 8'h00;
            acl_q <= 12'h000;
            acl_en_q <= 1'b0;
            lcl_q <= 12'h000;
            stall_q <= 1'b0;
            cla_q <= 16'h0000;
            cla_inf_q <= 1'b0;
            dtns_q <= 10'h000;
            dtcyc_q <= 8'h00;
        end else begin
            coef_q <= coef_d;
            acc2_q <= acc2_d;
            acc1_q <= acc1_d;
            thr_q <= thr_d;
            thr_ok_q <= thr_ok_d;
            align_q <= align_d;
            en_q <= en_d;
            acl_q <= acl_d;
            acl_en_q <= acl_en_d;
            lcl_q <= lcl_d;
            stall_q <= stall_d;
            cla_q <= cla_d;
            cla_inf_q <= cla_inf_d;
            dtns_q <= dtns_d;
            dtcyc_q <= dtcyc_d;
        end
    end

    // transfer request holds for the rest of the run; disable drops it on the next clock edge
    logic req_q, req_d;
    logic brake_q, brake_d;
    logic hiz_q, hiz_d;
    always_comb begin
        req_d = req_q;
        if (!open_loop_run || closed_loop_transfer_disable) begin
            req_d = 1'b0;
        end else if (thr_ok_q && (12'(motor_speed) >= thr_q)) begin
            req_d = 1'b1;
        end
        brake_d = sense_release && !en_q[0];
        hiz_d = sense_release && en_q[0];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            req_q <= 1'b0;
            brake_q <= 1'b0;
            hiz_q <= 1'b0;
        end else begin
            req_q <= req_d;
            brake_q <= brake_d;
            hiz_q <= hiz_d;
        end
    end

    // release overrides the core: brake pulls all low sides on, float turns all gates off
    genvar g;
    generate
        for (g = 0; g < PHASES; g++) begin : g_leg
            logic leg_en;
            logic leg_high;
            assign leg_en = brake_q || (!hiz_q && phase_drive_en[g]);
            assign leg_high = !brake_q && phase_drive_high[g];
            mso_deadtime u_dt (
                .clk(clk),
                .reset_n(reset_n),
                .drive_en(leg_en),
                .drive_high(leg_high),
                .dead_cycles(dtcyc_q),
                .gate_hs(gate_hs[g]),
                .gate_ls(gate_ls[g])
            );
        end
    endgenerate

    assign control_coefficient = coef_q;
    assign startup_accel_second_order = acc2_q;
    assign startup_accel_first_order = acc1_q;
    assign loop_transfer_threshold = thr_q;
    assign loop_transfer_threshold_valid = thr_ok_q;
    assign align_duration = align_q;
    assign no_motor_fault_enable = en_q[7];
    assign lock_detect_enables = en_q[6:4];
    assign inductive_surge_protect_enable = en_q[3];
    assign mechanical_surge_protect_enable = en_q[2];
    assign mechanical_surge_clamp_select = en_q[1];
    assign sense_release_mode = en_q[0];
    assign accel_current_limit = acl_q;
    assign accel_current_limit_enable = acl_en_q;
    assign lock_current_limit = lcl_q;
    assign closed_loop_stall_enable = stall_q;
    assign closed_loop_accel_rate = cla_q;
    assign closed_loop_accel_unlimited = cla_inf_q;
    assign dead_time_ns = dtns_q;
    assign closed_loop_request = req_q;
    assign phase_brake = brake_q;
    assign phase_hiz = hiz_q;

    property p_coef;
        @(posedge clk) disable iff (!reset_n)
        cfg.update |=> control_coefficient == 3'($past(cfg.startup.coef)) + 3'h1;
    endproperty
    a_coef: assert property (p_coef) else $error("coefficient decode wrong");
    property p_thr_hi;
        @(posedge clk) disable iff (!reset_n)
        cfg.update && cfg.thr_align.range_hi |=>
            loop_transfer_threshold == 12'((12'($past(cfg.thr_align.thr_n)) + 12'h001) * 12'h080);
    endproperty
    a_thr_hi: assert property (p_thr_hi) else $error("high range threshold wrong");
    property p_thr_lo;
        @(posedge clk) disable iff (!reset_n)
        cfg.update && !cfg.thr_align.range_hi |=>
            (loop_transfer_threshold == 12'(12'($past(cfg.thr_align.thr_n)) * 12'h008))
            && (loop_transfer_threshold_valid == ($past(cfg.thr_align.thr_n) != 4'h0));
    endproperty
    a_thr_lo: assert property (p_thr_lo) else $error("low range threshold wrong");
    property p_acl;
        @(posedge clk) disable iff (!reset_n)
        cfg.update |=> accel_current_limit_enable == (accel_current_limit != 12'h000);
    endproperty
    a_acl: assert property (p_acl) else $error("limit enable mismatch");
    property p_dead;
        @(posedge clk) disable iff (!reset_n)
        cfg.update && (cfg.closed.dead == 4'h9) |=> dead_time_ns == 10'h190;
    endproperty
    a_dead: assert property (p_dead) else $error("dead time decode wrong");
    property p_hold;
        @(posedge clk) disable iff (!reset_n)
        !load |=> $stable(dead_time_ns) && $stable(lock_detect_enables) && $stable(align_duration);
    endproperty
    a_hold: assert property (p_hold) else $error("setting moved without write");
    property p_fault_bits;
        @(posedge clk) disable iff (!reset_n)
        cfg.update |=> (no_motor_fault_enable == $past(cfg.fault.no_motor))
            && (lock_detect_enables == $past(cfg.fault.lock_det))
            && (mechanical_surge_clamp_select == $past(cfg.fault.clamp_24v));
    endproperty
    a_fault_bits: assert property (p_fault_bits) else $error("enable bit not followed");
    sequence s_reach;
        open_loop_run && !closed_loop_transfer_disable && loop_transfer_threshold_valid
            && (12'(motor_speed) >= loop_transfer_threshold);
    endsequence
    property p_transfer;
        @(posedge clk) disable iff (!reset_n) s_reach |=> closed_loop_request;
    endproperty
    a_transfer: assert property (p_transfer) else $error("no closed loop transfer");
    property p_no_transfer;
        @(posedge clk) disable iff (!reset_n) closed_loop_transfer_disable |=> !closed_loop_request;
    endproperty
    a_no_transfer: assert property (p_no_transfer) else $error("transfer while disabled");
    property p_release;
        @(posedge clk) disable iff (!reset_n)
        sense_release |=> (phase_brake == !$past(sense_release_mode)) && (phase_hiz == $past(sense_release_mode));
    endproperty
    a_release: assert property (p_release) else $error("release action wrong");
endmodule

// >>> test/mso_startup_option_regs_bench.sv
// self-checking bench for the start-up option register bank
`timescale 1ns/1ps
module mso_startup_option_regs_bench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wr = 1'b0, rd = 1'b0, run = 1'b0, dis = 1'b0, rel = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
    logic [11:0] speed = 12'h000;
    logic rvalid, thr_ok, nomo, ind, mech, clamp, mode, acl_en, stall, unl, req, brake, hiz;
    logic [2:0] coef, lock;
    logic [15:0] acc2, align, cla;
    logic [16:0] acc1;
    logic [11:0] thr, acl, lcl;
    logic [9:0] dead;
    logic [2:0] den = 3'h0, dhi = 3'h0, ghs, gls;
    int fails = 0, n_compared = 0, i;
    mso_startup_option_regs u_dut (.clk(clk), .reset_n(reset_n), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .open_loop_run(run), .motor_speed(speed),
        .closed_loop_transfer_disable(dis), .sense_release(rel), .phase_drive_en(den), .phase_drive_high(dhi),
        .control_coefficient(coef), .startup_accel_second_order(acc2), .startup_accel_first_order(acc1),
        .loop_transfer_threshold(thr), .loop_transfer_threshold_valid(thr_ok), .align_duration(align),
        .no_motor_fault_enable(nomo), .lock_detect_enables(lock), .inductive_surge_protect_enable(ind),
        .mechanical_surge_protect_enable(mech), .mechanical_surge_clamp_select(clamp),
        .sense_release_mode(mode), .accel_current_limit(acl), .accel_current_limit_enable(acl_en),
        .lock_current_limit(lcl), .closed_loop_stall_enable(stall), .closed_loop_accel_rate(cla),
        .closed_loop_accel_unlimited(unl), .dead_time_ns(dead), .closed_loop_request(req),
        .phase_brake(brake), .phase_hiz(hiz), .gate_hs(ghs), .gate_ls(gls));
    // free-running 100 MHz clock
    always #5 clk = ~clk;
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // one-cycle strobe, then wait until the decoded outputs have settled
    task wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = v;
        @(negedge clk);
        wr = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // bounded wait for the read answer, never an open-ended loop
    task rd_reg(input logic [7:0] a, input logic [7:0] e);
        int k;
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        for (k = 0; k < 3; k++) begin
            @(negedge clk);
            rd = 1'b0;
            if (rvalid === 1'b1) break;
        end
        chk("rvalid", {31'h0, rvalid}, 32'h1);
        chk("rdata", {24'h0, rdata}, {24'h0, e});
    endtask
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // a hang shows up as a failure, not a silent stop
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
    initial begin
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        // decoded settings of all-zero registers
        chk("coef", coef, 32'h1);
        chk("acc2", acc2, 32'hDEA8);
        chk("acc1", acc1, 32'h128E0);
        chk("thr_ok", thr_ok, 32'h0);
        chk("align", align, 32'h14B4);
        chk("lcl", lcl, 32'h190);
        chk("unl", unl, 32'h1);
        chk("dead", dead, 32'h28);
        rd_reg(8'h25, 8'h00);
        for (i = 0; i < 4; i++) begin
            wr_reg(8'h25, {i[1:0], 6'h3F});
            chk("coef", coef, 32'(i + 1));
        end
        chk("acc2", acc2, 32'hDC);
        chk("acc1", acc1, 32'h12C);
        rd_reg(8'h25, 8'hFF);
        wr_reg(8'h26, 8'hFF);
        chk("thr", thr, 32'h800);
        wr_reg(8'h26, 8'h80);
        chk("thr", thr, 32'h80);
        chk("align", align, 32'h14B4);
        wr_reg(8'h26, 8'h0F);
        chk("thr", thr, 32'h8);
        chk("thr_ok", thr_ok, 32'h1);
        chk("align", align, 32'h28);
        // both polarities of every enable bit
        for (i = 0; i < 2; i++) begin
            d = (i == 0) ? 8'hA5 : 8'h5A;
            wr_reg(8'h27, d);
            chk("nomo", nomo, d[7]);
            chk("lock", lock, d[6:4]);
            chk("ind", ind, d[3]);
            chk("mech", mech, d[2]);
            chk("clamp", clamp, d[1]);
            chk("mode", mode, d[0]);
        end
        rel = 1'b1;
        repeat (2) @(negedge clk);
        chk("brake", {hiz, brake}, 32'h1);
        wr_reg(8'h27, 8'hA5);
        chk("hiz", {hiz, brake}, 32'h2);
        rel = 1'b0;
        // spare bit of the limit register is never stored
        wr_reg(8'h28, 8'hFF);
        rd_reg(8'h28, 8'hFE);
        chk("acl", {acl_en, acl}, 32'h1BB8);
        chk("lcl", lcl, 32'hC80);
        wr_reg(8'h29, 8'hF9);
        chk("stall", stall, 32'h1);
        chk("cla", {unl, cla}, 32'h2D);
        chk("dead", dead, 32'h190);
        wr_reg(8'h30, 8'hAA);
        rd_reg(8'h30, 8'h00);
        chk("dead", dead, 32'h190);
        // gate gap of (9+1) x 40 ns is 40 clock cycles on every leg
        @(negedge clk);
        den = 3'h7;
        dhi = 3'h7;
        @(negedge clk);
        chk("ghs", ghs, 32'h7);
        dhi = 3'h0;
        repeat (40) @(negedge clk);
        chk("gap", {ghs, gls}, 32'h0);
        @(negedge clk);
        chk("gls", {ghs, gls}, 32'h7);
        den = 3'h0;
        // a read in the very next cycle sees the write just taken
        @(negedge clk);
        wr = 1'b1;
        addr = 8'h29;
        wdata = 8'h89;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk("rvalid", {31'h0, rvalid}, 32'h1);
        chk("rdata", {24'h0, rdata}, 32'h89);
        chk("cla", {unl, cla}, 32'h10000);
        // loop transfer at the 0.8 Hz threshold edge
        run = 1'b1;
        speed = 12'h007;
        repeat (3) @(negedge clk);
        chk("req", req, 32'h0);
        speed = 12'h008;
        repeat (2) @(negedge clk);
        chk("req", req, 32'h1);
        dis = 1'b1;
        repeat (2) @(negedge clk);
        chk("req", req, 32'h0);
        dis = 1'b0;
        repeat (2) @(negedge clk);
        chk("req", req, 32'h1);
        // end of open-loop run also drops the request
        run = 1'b0;
        repeat (2) @(negedge clk);
        chk("req", req, 32'h0);
        // mid-run reset puts every register back to zero
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        chk("dead", dead, 32'h28);
        rd_reg(8'h29, 8'h00);
        give_verdict();
    end
endmodule
